// ### rtl/pgs_ctrl.sv
// Top of the pulse-mode gain step controller: register port and two channels.
// Assumes a software master on the same clock; amplifier pins are plain outputs.
`timescale 1ns/10ps
module pgs_ctrl
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  // Amplifier mode and step pins
  output logic mode_select_high_r,
  output logic mode_select_low_r,
  output logic [1:0] step_size_r,
  // Channel A pins
  output logic gain_increase_strobe_a_n_r,
  output logic gain_decrease_strobe_a_n_r,
  output logic channel_a_active_pin_r,
  // Channel B pins
  output logic gain_increase_strobe_b_n_r,
  output logic gain_decrease_strobe_b_n_r,
  output logic channel_b_active_pin_r
);
  logic [3:0] ctrl_r;
  logic [1:0] pend_up_r;
  logic [1:0] pend_down_r;
  logic [1:0] pend_max_r;
  logic [1:0] start;
  logic [1:0] busy;
  logic [1:0] done;
  pgs_cmd_t req_cmd [2];
  pgs_cmd_t run_cmd [2];
  logic [5:0] gain [2];
  logic [1:0] up_n;
  logic [1:0] down_n;
  logic [1:0] cmd_wr;
  logic [7:0] rd_mux;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_select_high_r <= 1'b1;
      mode_select_low_r <= 1'b1;
    end
    else
    begin
      mode_select_high_r <= MODE_HIGH_PULSE;
      mode_select_low_r <= MODE_LOW_PULSE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_r <= CTRL_RESET;
    else if (reg_wr && reg_addr == ADDR_CTRL)
      ctrl_r <= reg_wdata[3:0];
  end

  // Step pins and enables follow the control register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      step_size_r <= STEP_HALF;
      channel_a_active_pin_r <= 1'b1;
      channel_b_active_pin_r <= 1'b1;
    end
    else
    begin
      step_size_r <= ctrl_r[CTRL_STEP_LSB +: 2];
      channel_a_active_pin_r <= ctrl_r[CTRL_EN_A_BIT];
      channel_b_active_pin_r <= ctrl_r[CTRL_EN_B_BIT];
    end
  end

  assign cmd_wr = (reg_wr && reg_addr == ADDR_CMD) ? 2'b11 : 2'b00;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      // Pending requests; a new write sets, launch clears, set wins
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          pend_up_r[ch] <= 1'b0;
          pend_down_r[ch] <= 1'b0;
          pend_max_r[ch] <= 1'b0;
        end
        else
        begin
          pend_up_r[ch] <= (cmd_wr[ch] && reg_wdata[2*ch+CMD_UP_BIT]) ||
            (pend_up_r[ch] && !(start[ch] && req_cmd[ch] == CMD_UP));
          pend_down_r[ch] <= (cmd_wr[ch] && reg_wdata[2*ch+CMD_DOWN_BIT]) ||
            (pend_down_r[ch] && !(start[ch] && req_cmd[ch] == CMD_DOWN));
          pend_max_r[ch] <= (cmd_wr[ch] && reg_wdata[CMD_MAX_BIT+ch]) ||
            (pend_max_r[ch] && !(start[ch] && req_cmd[ch] == CMD_MAX));
        end
      end

      // Reset request outranks steps; up before down
      always_comb
      begin
        if (pend_max_r[ch])
          req_cmd[ch] = CMD_MAX;
        else if (pend_up_r[ch])
          req_cmd[ch] = CMD_UP;
        else
          req_cmd[ch] = CMD_DOWN;
      end

      // Strobes run while disabled; the amplifier keeps state across enable
      assign start[ch] = !busy[ch] && (pend_max_r[ch] || pend_up_r[ch] || pend_down_r[ch]);

      pgs_strobe_seq u_seq
      (
        .clk(clk),
        .srst(srst),
        .start(start[ch]),
        .cmd(req_cmd[ch]),
        .busy_r(busy[ch]),
        .done_r(done[ch]),
        .cmd_r(run_cmd[ch]),
        .up_strobe_n_r(up_n[ch]),
        .down_strobe_n_r(down_n[ch])
      );

      pgs_gain_track u_trk
      (
        .clk(clk),
        .srst(srst),
        .done(done[ch]),
        .cmd(run_cmd[ch]),
        .step_sel(step_size_r),
        .gain_r(gain[ch])
      );
    end
  endgenerate

  // Strobe pins straight from sequencer flip-flops
  assign gain_increase_strobe_a_n_r = up_n[0];
  assign gain_decrease_strobe_a_n_r = down_n[0];
  assign gain_increase_strobe_b_n_r = up_n[1];
  assign gain_decrease_strobe_b_n_r = down_n[1];

  always_comb
  begin
    case (reg_addr)
      ADDR_CTRL: rd_mux = {4'h0, ctrl_r};
      ADDR_STAT: rd_mux = {pend_max_r, pend_down_r, pend_up_r, busy};
      ADDR_GAIN_A: rd_mux = {2'h0, gain[0]};
      ADDR_GAIN_B: rd_mux = {2'h0, gain[1]};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rd_mux;
    else
      reg_rdata_r <= 8'h00;
  end

  AST_MODE_PINS: assert property (@(posedge clk) disable iff (srst)
    $past(srst) == 1'b0 |-> (!mode_select_high_r && mode_select_low_r))
    else $error("mode pins not in pulse mode");
  AST_ENABLE_FOLLOW: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == ADDR_CTRL) |-> ##2 channel_b_active_pin_r == $past(reg_wdata[1], 2))
    else $error("enable pin did not follow control write");
  AST_STEP_FOLLOW: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == ADDR_CTRL) |-> ##2 step_size_r == $past(reg_wdata[3:2], 2))
    else $error("step pins did not follow control write");
  AST_LAUNCH: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == ADDR_CMD && reg_wdata[0] && !busy[0] && !pend_max_r[0]
      && !pend_up_r[0] && !pend_down_r[0]) |-> ##2 !gain_increase_strobe_a_n_r)
    else $error("increase request did not launch a pulse");
endmodule

// ### rtl/pgs_pkg.sv
// Constants for the pulse-mode gain step controller.
// Assumes a 10 MHz system clock and a dual-channel amplifier driven by pins.
// Overview of operation
// - The controller puts the amplifier in pulse mode by driving the high mode pin 0 and the low mode pin 1.
// - Two step-size pins, driven here from a software register, pick the step size.
// - Every strobe is held high at least 20 ns and low at least 20 ns for a pulse to count.
// - A reset keeps both strobes low together for an overlap of at least 20 ns.
package pgs_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int STROBE_HIGH_MIN_TIME_NS = 20;
  localparam int STROBE_LOW_MIN_TIME_NS = 20;
  localparam int RESET_OVERLAP_MIN_TIME_NS = 20;
  localparam int HIGH_CYC_RAW = (STROBE_HIGH_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC_RAW = (STROBE_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC_RAW = (RESET_OVERLAP_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (HIGH_CYC_RAW < 1) ? 1 : HIGH_CYC_RAW;
  localparam int STROBE_LOW_CYC = (LOW_CYC_RAW < 1) ? 1 : LOW_CYC_RAW;
  localparam int RESET_OVERLAP_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam int CNT_W = 4;
  // Mode pins for pulse mode
  localparam logic MODE_HIGH_PULSE = 1'b0;
  localparam logic MODE_LOW_PULSE = 1'b1;
  // Register addresses (4-bit port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_GAIN_A = 4'h3;
  localparam logic [3:0] ADDR_GAIN_B = 4'h4;
  // CTRL fields
  localparam int CTRL_EN_A_BIT = 0;
  localparam int CTRL_EN_B_BIT = 1;
  localparam int CTRL_STEP_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h3;
  // CMD fields: bit0 up A, bit1 down A, bit2 up B, bit3 down B, bit4 max A, bit5 max B
  localparam int CMD_UP_BIT = 0;
  localparam int CMD_DOWN_BIT = 1;
  localparam int CMD_MAX_BIT = 4;
  // Step-size pin codes for half, one, two and six dB steps
  localparam logic [1:0] STEP_HALF = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam logic [1:0] STEP_SIX = 2'h3;
  localparam logic [5:0] GAIN_MAX_CODE = 6'h3f;
  localparam logic [5:0] GAIN_MIN_CODE = 6'h00;
  typedef enum logic [1:0] {CMD_UP, CMD_DOWN, CMD_MAX} pgs_cmd_t;
endpackage

// ### rtl/pgs_gain_track.sv
// Tracks one channel's expected gain code as the amplifier would hold it.
// Assumes one done strobe per completed pulse from the sequencer.
`timescale 1ns/10ps
module pgs_gain_track
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Completed pulse
  input wire logic done,
  input wire pgs_cmd_t cmd,
  input wire logic [1:0] step_sel,
  // Tracked state
  output logic [5:0] gain_r
);
  logic [5:0] inc;
  logic [6:0] up_sum;

  always_comb
  begin
    case (step_sel)
      STEP_HALF: inc = 6'h01;
      STEP_ONE: inc = 6'h02;
      STEP_TWO: inc = 6'h04;
      default: inc = 6'h0c;
    endcase
    up_sum = {1'b0, gain_r} + {1'b0, inc};
  end

  // Code is gain in half-dB units; max code is 31.5 dB
  always_ff @(posedge clk)
  begin
    if (srst)
      gain_r <= GAIN_MAX_CODE;
    else if (done)
    begin
      case (cmd)
        CMD_MAX: gain_r <= GAIN_MAX_CODE;
        CMD_UP: gain_r <= up_sum[6] ? GAIN_MAX_CODE : up_sum[5:0];
        CMD_DOWN: gain_r <= (gain_r < inc) ? GAIN_MIN_CODE : gain_r - inc;
        default: gain_r <= gain_r;
      endcase
    end
  end

  AST_SAT_UP: assert property (@(posedge clk) disable iff (srst)
    (done && cmd == CMD_UP && gain_r == GAIN_MAX_CODE) |=> gain_r == GAIN_MAX_CODE)
    else $error("gain wrapped past maximum");
  AST_SAT_DOWN: assert property (@(posedge clk) disable iff (srst)
    (done && cmd == CMD_DOWN && gain_r == GAIN_MIN_CODE) |=> gain_r == GAIN_MIN_CODE)
    else $error("gain wrapped past minimum");
  AST_HOLD: assert property (@(posedge clk) disable iff (srst)
    !done |=> $stable(gain_r))
    else $error("gain changed without a pulse");
endmodule

// ### rtl/pgs_strobe_seq.sv
// Pulse sequencer for one channel's active-low increase and decrease strobes.
// Assumes start only while busy is low; timing counts come from the package.
`timescale 1ns/10ps
module pgs_strobe_seq
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Request
  input wire logic start,
  input wire pgs_cmd_t cmd,
  // Status
  output logic busy_r,
  output logic done_r,
  output pgs_cmd_t cmd_r,
  // Pins, active low
  output logic up_strobe_n_r,
  output logic down_strobe_n_r
);
  typedef enum logic [1:0] {SQ_IDLE, SQ_LOW, SQ_HIGH} pgs_seq_t;
  pgs_seq_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] low_len;

  assign low_len = (cmd_r == CMD_MAX) ? CNT_W'(RESET_OVERLAP_CYC) : CNT_W'(STROBE_LOW_CYC);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= SQ_IDLE;
      cnt_r <= '0;
      cmd_r <= CMD_UP;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      up_strobe_n_r <= 1'b1;
      down_strobe_n_r <= 1'b1;
    end
    else
    begin
      done_r <= 1'b0;
      case (st_r)
        SQ_IDLE:
        if (start)
        begin
          st_r <= SQ_LOW;
          cmd_r <= cmd;
          cnt_r <= '0;
          busy_r <= 1'b1;
          up_strobe_n_r <= !(cmd == CMD_UP || cmd == CMD_MAX);
          down_strobe_n_r <= !(cmd == CMD_DOWN || cmd == CMD_MAX);
        end
        SQ_LOW:
        if (cnt_r + 1'b1 >= low_len)
        begin
          // Both strobes rise together so a reset never leaves a lone step
          st_r <= SQ_HIGH;
          cnt_r <= '0;
          up_strobe_n_r <= 1'b1;
          down_strobe_n_r <= 1'b1;
          done_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
        SQ_HIGH:
        if (cnt_r + 1'b1 >= CNT_W'(STROBE_HIGH_CYC))
        begin
          st_r <= SQ_IDLE;
          busy_r <= 1'b0;
        end
        else
          cnt_r <= cnt_r + 1'b1;
        default: st_r <= SQ_IDLE;
      endcase
    end
  end

  AST_LOW_MIN: assert property (@(posedge clk) disable iff (srst)
    $fell(up_strobe_n_r) |-> !up_strobe_n_r [*1] ##1 1)
    else $error("increase strobe low too short");
  AST_HIGH_GAP: assert property (@(posedge clk) disable iff (srst)
    $rose(up_strobe_n_r) |=> up_strobe_n_r)
    else $error("increase strobe high too short");
  AST_RESET_OVERLAP: assert property (@(posedge clk) disable iff (srst)
    (!up_strobe_n_r && !down_strobe_n_r) |-> (st_r == SQ_LOW && cmd_r == CMD_MAX))
    else $error("both strobes low outside a reset");
  AST_DONE_AT_RISE: assert property (@(posedge clk) disable iff (srst)
    done_r |-> (up_strobe_n_r && down_strobe_n_r && $past(st_r) == SQ_LOW))
    else $error("step applied before pulse ended");
endmodule

// ### testbench/pgs_amp_chan.sv
// Behavioural model of one amplifier channel in pulse mode.
// Assumes strobe edges come from clocked logic, at least 1 ns apart.
`timescale 1ns/10ps
module pgs_amp_chan
  import pgs_pkg::*;
(
  // Mode and step pins
  input wire logic pulse_mode,
  input wire logic [1:0] step_size,
  // Channel pins
  input wire logic up_n,
  input wire logic down_n,
  input wire logic enable,
  // Observed state
  output logic [5:0] gain,
  output logic powered
);
  realtime up_fall = 0, down_fall = 0, up_rise = 0, down_rise = 0, both_t = 0, now = 0;
  logic prev_up = 1'b1;
  logic prev_down = 1'b1;
  logic rst_f = 1'b0;
  int sz;
  assign powered = enable;
  // Gain is held whatever the enable does
  initial gain = GAIN_MAX_CODE;
  always @(up_n or down_n)
  begin
    #1;
    now = $realtime;
    sz = (step_size == STEP_HALF) ? 1 : (step_size == STEP_ONE) ? 2 :
      (step_size == STEP_TWO) ? 4 : 12;
    if (pulse_mode)
    begin
      if (!up_n && !down_n && (prev_up || prev_down))
        both_t = now;
      if ((up_n || down_n) && !prev_up && !prev_down && now - both_t >= 20.0)
      begin
        gain = GAIN_MAX_CODE;
        rst_f = 1'b1;
      end
      if (up_n && !prev_up && !rst_f && now - up_fall >= 20.0 && up_fall - up_rise >= 20.0)
        gain = (int'(gain) + sz > 63) ? GAIN_MAX_CODE : gain + 6'(sz);
      if (down_n && !prev_down && !rst_f && now - down_fall >= 20.0
        && down_fall - down_rise >= 20.0)
        gain = (int'(gain) < sz) ? GAIN_MIN_CODE : gain - 6'(sz);
    end
    if (up_n && !prev_up) up_rise = now;
    if (!up_n && prev_up) up_fall = now;
    if (down_n && !prev_down) down_rise = now;
    if (!down_n && prev_down) down_fall = now;
    if (up_n && down_n) rst_f = 1'b0;
    prev_up = up_n;
    prev_down = down_n;
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench: register port tasks, amplifier model on the pins.
// Assumes the register map and pin timing of the controller hand-over.
`timescale 1ns/10ps
module tb_top;
  import pgs_pkg::*;
  logic clk, srst, reg_wr, reg_rd, msh, msl, up_a_n, down_a_n, en_a, up_b_n, down_b_n, en_b;
  logic on_a, on_b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r, d;
  logic [1:0] step_pin;
  logic [5:0] amp_a, amp_b, exp_a, exp_b;
  int mismatches, checked;
  pgs_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .mode_select_high_r(msh),
    .mode_select_low_r(msl), .step_size_r(step_pin), .gain_increase_strobe_a_n_r(up_a_n),
    .gain_decrease_strobe_a_n_r(down_a_n), .channel_a_active_pin_r(en_a),
    .gain_increase_strobe_b_n_r(up_b_n), .gain_decrease_strobe_b_n_r(down_b_n),
    .channel_b_active_pin_r(en_b));
  pgs_amp_chan amp_a_i (.pulse_mode(!msh && msl), .step_size(step_pin), .up_n(up_a_n),
    .down_n(down_a_n), .enable(en_a), .gain(amp_a), .powered(on_a));
  pgs_amp_chan amp_b_i (.pulse_mode(!msh && msl), .step_size(step_pin), .up_n(up_b_n),
    .down_n(down_b_n), .enable(en_b), .gain(amp_b), .powered(on_b));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata_r;
  endtask
  function automatic logic [5:0] nxt(input logic [5:0] g, input logic [1:0] s, input bit up);
    int z;
    z = (s == STEP_HALF) ? 1 : (s == STEP_ONE) ? 2 : (s == STEP_TWO) ? 4 : 12;
    z = up ? int'(g) + z : int'(g) - z;
    return (z > 63) ? 6'h3f : (z < 0) ? 6'h00 : 6'(z);
  endfunction
  task automatic check_gains();
    rd(ADDR_GAIN_A, d);
    chk("gain_a", d, {2'b00, exp_a});
    rd(ADDR_GAIN_B, d);
    chk("gain_b", d, {2'b00, exp_b});
    chk("amp_a", {2'b00, amp_a}, {2'b00, exp_a});
    chk("amp_b", {2'b00, amp_b}, {2'b00, exp_b});
  endtask
  task automatic op(input logic [7:0] c);
    int n;
    n = 0;
    wr(ADDR_CMD, c);
    d = 8'hff;
    while (d !== 8'h00 && n < 40)
    begin
      rd(ADDR_STAT, d);
      n++;
    end
    chk("idle", d, 8'h00);
    check_gains();
  endtask
  task automatic ctrl(input logic [1:0] s, input logic [1:0] en);
    wr(ADDR_CTRL, {4'h0, s, en});
    @(posedge clk);
    #1;
    chk("step_pins", {6'h00, step_pin}, {6'h00, s});
    chk("en_pins", {6'h00, en_b, en_a}, {6'h00, en});
    chk("powered", {6'h00, on_b, on_a}, {6'h00, en});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(3000 * 100);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end
  initial
  begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 14'h0};
    {mismatches, checked} = '0;
    exp_a = GAIN_MAX_CODE;
    exp_b = GAIN_MAX_CODE;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("mode_pins", {6'h00, msh, msl}, {6'h00, MODE_HIGH_PULSE, MODE_LOW_PULSE});
    rd(ADDR_CTRL, d);
    chk("ctrl_reset", d, {4'h0, CTRL_RESET});
    rd(4'hf, d);
    chk("unmapped", d, 8'h00);
    check_gains();
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      ctrl(2'(s), 2'b11);
      exp_a = nxt(exp_a, 2'(s), 1'b0);
      op(8'h02);
    end
    exp_a = nxt(exp_a, STEP_SIX, 1'b1);
    op(8'h01);
    op(8'h04);
    repeat (5)
    begin
      exp_a = nxt(exp_a, STEP_SIX, 1'b0);
      op(8'h02);
    end
    $display("test steps done");
    exp_a = nxt(GAIN_MAX_CODE, STEP_SIX, 1'b0);
    op(8'h13);
    $display("test max done");
    ctrl(STEP_SIX, 2'b10);
    exp_b = nxt(exp_b, STEP_SIX, 1'b0);
    op(8'h08);
    wr(ADDR_GAIN_A, 8'h00);
    check_gains();
    ctrl(STEP_SIX, 2'b11);
    rd(ADDR_CTRL, d);
    chk("ctrl_rb", d, 8'h0f);
    exp_a = nxt(exp_a, STEP_SIX, 1'b0);
    exp_b = nxt(exp_b, STEP_SIX, 1'b0);
    op(8'h0a);
    $display("test enable done");
    complete_run();
  end
endmodule
